/* rcc_ctrl.sv */
/*
  Clock/calendar control register block: Wishbone slave with the control
  register, unlock key port and seconds field, the clock-source divider,
  the trimmed prescaler and the seconds/alarm output pin.
  Assumes rst_i is the power-on reset and sw_rst_i any other reset source;
  alarm_pulse_i comes from alarm logic outside this block.
*/
`default_nettype none

module rcc_ctrl
  import rcc_pkg::*;
#(
  parameter int RTC_DIV       = RTC_DIV_DEF,
  parameter int TICKS_PER_SEC = RTC_HZ
) (
  // Clock and resets
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             sw_rst_i,
  // Wishbone slave
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Power state
  input  wire logic             idle_i,
  output logic                  peripheral_bus_clock_en_o,
  // Alarm source and output pin
  input  wire logic             alarm_pulse_i,
  output logic                  pin_o,
  output logic                  pin_oe_n_o,
  // Unit status
  output logic                  unit_on_o,
  output logic                  clock_running_flag_o
);

  localparam int DW = $clog2(RTC_DIV);

  if (RTC_DIV < 2) begin : g_chk_div
    $error("RTC_DIV must be at least 2");
  end

  // Control register fields
  logic [CAL_W-1:0] cal;
  logic             unit_on;
  logic             stop_when_idle;
  logic             pin_source_select;
  logic             write_unlock;
  logic             pin_output_enable;

  // Bus decode
  logic             req;
  logic             wr;
  logic             rd;
  logic             hit_ctrl;
  logic             hit_key;
  logic             hit_time;
  logic [31:0]      ctrl_rd;
  logic [31:0]      time_rd;
  logic [31:0]      next_dat;

  // Unlock sequencing
  rcc_key_t         key_state;
  rcc_key_t         next_key_state;

  // Time base
  logic [DW-1:0]    div_cnt;
  logic             tick;
  logic             run;
  logic             idle_stop;
  logic             sec_load;
  logic [5:0]       sec;
  logic             half_second_flag;
  logic             rollover_sync_flag;
  logic             clock_running_flag;
  logic             soft_rst;

  // Merge a byte-lane write into a 32-bit value
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] data,
                                             input logic [3:0]  sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    lane_merge = res;
  endfunction

  // Word-aligned decode of the byte address
  function automatic logic adr_is(input logic [ADR_W-1:0] adr,
                                  input logic [3:0]       ofs);
    adr_is = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
  endfunction

  assign soft_rst = rst_i | sw_rst_i;

  assign req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge that sees ack, where the master commits
  assign wr       = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign rd       = req & ~wb_we_i;
  assign hit_ctrl = adr_is(wb_adr_i, OFS_CTRL);
  assign hit_key  = adr_is(wb_adr_i, OFS_KEY);
  assign hit_time = adr_is(wb_adr_i, OFS_TIME);

  // Ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Control register image on read
  always_comb begin
    ctrl_rd                          = 32'h00000000;
    ctrl_rd[CAL_LSB +: CAL_W]        = cal;
    ctrl_rd[ON_BIT]                  = unit_on;
    ctrl_rd[STOP_IDLE_BIT]           = stop_when_idle;
    ctrl_rd[SSEL_BIT]                = pin_source_select;
    ctrl_rd[CLKON_BIT]               = clock_running_flag;
    ctrl_rd[WREN_BIT]                = write_unlock;
    ctrl_rd[SYNC_BIT]                = rollover_sync_flag;
    ctrl_rd[HALF_BIT]                = half_second_flag;
    ctrl_rd[OE_BIT]                  = pin_output_enable;
  end

  always_comb begin
    time_rd                        = 32'h00000000;
    time_rd[SEC_LSB +: SEC_W]      = {1'b0, sec};
  end

  // Unmapped and key addresses read as zero
  always_comb begin
    next_dat = 32'h00000000;
    if (hit_ctrl) begin
      next_dat = ctrl_rd;
    end else if (hit_time) begin
      next_dat = time_rd;
    end
  end

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd) begin
      wb_dat_o <= next_dat;
    end
  end

  // Two consecutive key writes open one control write
  always_comb begin
    next_key_state = key_state;
    if (wr) begin
      unique case (key_state)
        RCC_KEY_IDLE: begin
          if (hit_key && wb_dat_i == UNLOCK_KEY1 && wb_sel_i == 4'hF) begin
            next_key_state = RCC_KEY_HALF;
          end
        end
        RCC_KEY_HALF: begin
          if (hit_key && wb_dat_i == UNLOCK_KEY2 && wb_sel_i == 4'hF) begin
            next_key_state = RCC_KEY_OPEN;
          end else begin
            next_key_state = RCC_KEY_IDLE;
          end
        end
        RCC_KEY_OPEN: begin
          next_key_state = RCC_KEY_IDLE;
        end
        default: begin
          next_key_state = RCC_KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      key_state <= RCC_KEY_IDLE;
    end else begin
      key_state <= next_key_state;
    end
  end

  // Control register; only power-on reset clears it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal               <= CAL_RST;
      unit_on           <= 1'b0;
      stop_when_idle    <= 1'b0;
      pin_source_select <= 1'b0;
      write_unlock      <= 1'b0;
      pin_output_enable <= 1'b0;
    end else if (wr && hit_ctrl) begin
      cal <= CAL_W'(lane_merge(32'(cal) << CAL_LSB, wb_dat_i,
                               wb_sel_i) >> CAL_LSB);
      if (wb_sel_i[ON_BIT/8]) begin
        if (write_unlock) begin
          unit_on <= wb_dat_i[ON_BIT];
        end
        stop_when_idle <= wb_dat_i[STOP_IDLE_BIT];
      end
      if (wb_sel_i[0]) begin
        pin_source_select <= wb_dat_i[SSEL_BIT];
        pin_output_enable <= wb_dat_i[OE_BIT];
        if (!wb_dat_i[WREN_BIT]) begin
          write_unlock <= 1'b0;
        end else if (key_state == RCC_KEY_OPEN) begin
          write_unlock <= 1'b1;
        end
      end
    end
  end

  assign idle_stop = stop_when_idle & idle_i;
  assign run       = unit_on & ~idle_stop;

  // Clock-source tick divider, frozen while not running
  always_ff @(posedge clk_i) begin
    if (soft_rst) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else if (!run) begin
      tick    <= 1'b0;
    end else if (div_cnt == DW'(RTC_DIV - 1)) begin
      div_cnt <= '0;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + DW'(1);
      tick    <= 1'b0;
    end
  end

  assign sec_load = wr & hit_time & wb_sel_i[SEC_LSB/8];

  rcc_prescaler #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_prescaler (
    .clk_i      (clk_i),
    .rst_i      (soft_rst),
    .tick_i     (tick & run),
    .trim_i     (cal),
    .load_i     (sec_load),
    .load_sec_i (wb_dat_i[SEC_LSB +: 6]),
    .sec_o      (sec),
    .half_o     (half_second_flag),
    .sync_o     (rollover_sync_flag)
  );

  // Status and power outputs from flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_running_flag        <= 1'b0;
      peripheral_bus_clock_en_o <= 1'b1;
    end else begin
      clock_running_flag        <= run;
      peripheral_bus_clock_en_o <= ~idle_stop;
    end
  end

  // Seconds clock is the half-second phase: high in the second half
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_o      <= 1'b0;
      pin_oe_n_o <= 1'b1;
    end else begin
      pin_o      <= pin_source_select ? half_second_flag : alarm_pulse_i;
      pin_oe_n_o <= ~pin_output_enable;
    end
  end

  assign unit_on_o            = unit_on;
  assign clock_running_flag_o = clock_running_flag;

endmodule

`default_nettype wire

/* rcc_ctrl_asserts.sv */
/*
  Port checker for rcc_ctrl, bound to every instance.
  Assumes synchronous active-high rst_i and one clock.
*/
`default_nettype none
module rcc_ctrl_asserts (
  // Clock, reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Power, pin, status
  input wire logic        idle_i,
  input wire logic        peripheral_bus_clock_en_o,
  input wire logic        pin_oe_n_o,
  input wire logic        unit_on_o,
  input wire logic        clock_running_flag_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_stb_i))
    else $error("ack without request");
  unused_zero_a: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i[3:2] == 2'h0 |-> (wb_dat_o & 32'hFC00_5F00) == 32'h0)
    else $error("unused control bit reads one");
  run_flag_a: assert property (!$past(unit_on_o) |-> !clock_running_flag_o)
    else $error("running while disabled");
  bus_clk_a: assert property (!$past(idle_i) |-> peripheral_bus_clock_en_o)
    else $error("bus clock cut outside idle");
  on_write_a: assert property ($changed(unit_on_o) |-> $past(wb_ack_o) && $past(wb_we_i))
    else $error("enable changed without write");
  oe_write_a: assert property ($changed(pin_oe_n_o) |-> $past(wb_ack_o, 2) && $past(wb_we_i, 2))
    else $error("pin enable changed without write");
  on_c: cover property ($rose(unit_on_o));
  gate_c: cover property ($fell(peripheral_bus_clock_en_o));
  oe_c: cover property ($fell(pin_oe_n_o));
endmodule

bind rcc_ctrl rcc_ctrl_asserts i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .idle_i, .peripheral_bus_clock_en_o, .pin_oe_n_o,
  .unit_on_o, .clock_running_flag_o);
`default_nettype wire

/* rcc_ctrl_tb.sv */
/*
  Bench for rcc_ctrl with a short time base and a pin receiver.
  Assumes the checker binds itself to the block.
*/
`default_nettype none
module rcc_ctrl_tb
  import rcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 2;
  localparam int TPS = 1024;
  logic clk_i = 1'h0, rst_i = 1'h1, sw_rst_i = 1'h0, idle_i = 1'h0, alm = 1'h0;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
  logic [3:0] adr = 4'h0, sel = 4'hF;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic ack, bus_en, pin, oe_n, on, run, line;
  int failures = 0, comparisons = 0, cycles = 0;
  always #2.5 clk_i = !clk_i;
  rcc_ctrl #(.RTC_DIV(DIV), .TICKS_PER_SEC(TPS)) i_dut (.clk_i, .rst_i, .sw_rst_i,
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .idle_i,
    .peripheral_bus_clock_en_o(bus_en), .alarm_pulse_i(alm), .pin_o(pin),
    .pin_oe_n_o(oe_n), .unit_on_o(on), .clock_running_flag_o(run));
  rcc_pin_model i_pin (.clk_i, .pin_i(pin), .pin_oe_n_i(oe_n), .line_o(line));
  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h", $time, what, got);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'h1) begin
      @(posedge clk_i);
    end
    rdat = dat_o;
    cyc <= 1'h0;
    stb <= 1'h0;
    @(posedge clk_i);
  endtask
  // Control word with the unlock bit kept set
  function automatic logic [31:0] cw(input logic [9:0] c, input logic o, s, q, e);
    return {6'h0, c, o, 1'h0, s, 5'h0, q, 3'h0, 1'h1, 2'h0, e};
  endfunction
  task automatic rdc(input logic [31:0] exp, input string what);
    bus(1'h0, OFS_CTRL, 32'h0);
    chk(rdat & 32'hFFFF_FFB9, exp, what);
  endtask
  task automatic wline(input logic v);
    while (line !== v) begin
      @(posedge clk_i);
    end
  endtask
  task automatic t_lock();
    rdc(32'h0, "reset value");
    bus(1'h1, OFS_CTRL, 32'hFFFF_FFFF);
    rdc(32'h03FF_2081, "locked write");
    sel <= 4'h2;
    bus(1'h1, OFS_CTRL, 32'h0);
    sel <= 4'hF;
    rdc(32'h03FF_0081, "lane write");
    bus(1'h0, 4'hC, 32'h0);
    chk(rdat, 32'h0, "unmapped");
    bus(1'h1, OFS_KEY, UNLOCK_KEY2);
    bus(1'h1, OFS_KEY, UNLOCK_KEY1);
    bus(1'h1, OFS_CTRL, cw(10'h0, 1'h1, 1'h0, 1'h0, 1'h0));
    rdc(32'h0, "keys out of order");
    $display("test lock done");
  endtask
  task automatic t_on();
    bus(1'h1, OFS_KEY, UNLOCK_KEY1);
    bus(1'h1, OFS_KEY, UNLOCK_KEY2);
    bus(1'h1, OFS_CTRL, cw(10'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    bus(1'h1, OFS_CTRL, cw(10'h0, 1'h1, 1'h0, 1'h0, 1'h0));
    repeat (3) @(posedge clk_i);
    bus(1'h0, OFS_CTRL, 32'h0);
    chk(rdat & 32'hFFFF_FFF9, 32'h0000_8048, "enabled");
    chk(32'(on), 32'h1, "unit on");
    bus(1'h1, OFS_CTRL, cw(10'h0, 1'h1, 1'h1, 1'h0, 1'h0));
    idle_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk(32'(bus_en), 32'h0, "idle gate");
    chk(32'(run), 32'h0, "idle halt");
    bus(1'h1, OFS_CTRL, cw(10'h0, 1'h0, 1'h0, 1'h0, 1'h0));
    @(posedge clk_i);
    chk(32'(bus_en) + 32'(run), 32'h1, "idle kept running");
    chk(32'(on), 32'h0, "unit off");
    idle_i <= 1'h0;
    $display("test enable done");
  endtask
  task automatic t_pin();
    alm <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk(32'(oe_n), 32'h1, "pin off");
    bus(1'h1, OFS_CTRL, cw(10'h0, 1'h0, 1'h0, 1'h0, 1'h1));
    @(posedge clk_i);
    chk(32'(line), 32'h1, "alarm high");
    alm <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk(32'(line), 32'h0, "alarm low");
    $display("test pin done");
  endtask
  task automatic t_trim(input logic [9:0] c);
    int t0;
    bus(1'h1, OFS_CTRL, cw(c, 1'h1, 1'h0, 1'h1, 1'h1));
    wline(1'h1);
    bus(1'h1, OFS_TIME, 32'h0000_3B00);
    bus(1'h0, OFS_CTRL, 32'h0);
    chk(32'(rdat[HALF_BIT]), 32'h0, "half cleared");
    wline(1'h1);
    t0 = cycles;
    wline(1'h0);
    chk(cycles - t0, (TPS / 2 + $signed(c)) * DIV, "trimmed second");
    wline(1'h1);
    t0 = cycles;
    wline(1'h0);
    chk(cycles - t0, TPS / 2 * DIV, "plain second");
    $display("test trim done");
  endtask
  task automatic t_rst();
    sw_rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    sw_rst_i <= 1'h0;
    @(posedge clk_i);
    rdc(cw(10'h301, 1'h1, 1'h0, 1'h1, 1'h1), "kept over reset");
    rst_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    rdc(32'h0, "power-on clear");
    $display("test reset done");
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'h0;
    t_lock();
    t_on();
    t_pin();
    t_trim(10'h1FF);
    t_trim(10'h3FF);
    t_trim(10'h301);
    t_rst();
    report_and_stop();
  end
endmodule
`default_nettype wire

/* rcc_pin_model.sv */
/*
  Receiver on the seconds/alarm pin.
  Assumes pin_oe_n_i low while the block drives the pin.
*/
`default_nettype none
module rcc_pin_model (
  // Clock
  input wire logic clk_i,
  // Pin
  input wire logic pin_i,
  input wire logic pin_oe_n_i,
  // Wire level
  output logic     line_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'h0;
  // Floating pin toggles so a stale level never matches
  always_ff @(posedge clk_i) begin
    last <= line_o;
  end
  assign line_o = pin_oe_n_i ? !last : pin_i;
endmodule
`default_nettype wire

/* rcc_pkg.sv */
/*
  Constants shared by the clock/calendar control block and its prescaler:
  register offsets, field positions, unlock keys, timing and key states.
  Assumes a 200 MHz system clock and a 32-bit Wishbone register bus.
*/
`default_nettype none

package rcc_pkg;

  // Timing
  localparam int CLK_HZ       = 200_000_000;
  localparam int RTC_HZ       = 32768;
  localparam int RTC_DIV_DEF  = CLK_HZ / RTC_HZ;
  localparam int SEC_PER_MIN  = 60;
  localparam int SYNC_WIN     = 32;

  // Register byte offsets
  localparam int         ADR_W    = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_KEY  = 4'h4;
  localparam logic [3:0] OFS_TIME = 4'h8;

  // Control register fields
  localparam int CAL_W   = 10;
  localparam int CAL_LSB = 16;
  localparam int ON_BIT  = 15;
  localparam int STOP_IDLE_BIT = 13;
  localparam int SSEL_BIT = 7;
  localparam int CLKON_BIT = 6;
  localparam int WREN_BIT = 3;
  localparam int SYNC_BIT = 2;
  localparam int HALF_BIT = 1;
  localparam int OE_BIT   = 0;

  // Time register seconds field
  localparam int SEC_LSB = 8;
  localparam int SEC_W   = 7;

  // Unlock sequence keys, arbitrary values
  localparam logic [31:0] UNLOCK_KEY1 = 32'h0000C35A;
  localparam logic [31:0] UNLOCK_KEY2 = 32'h00005AC3;

  // Reset values
  localparam logic [CAL_W-1:0] CAL_RST = 10'h000;

  typedef enum logic [2:0] {
    RCC_KEY_IDLE = 3'b001,
    RCC_KEY_HALF = 3'b010,
    RCC_KEY_OPEN = 3'b100
  } rcc_key_t;

endpackage

`default_nettype wire

/* rcc_prescaler.sv */
/*
  Seconds prescaler with once-per-minute drift trim.
  Assumes tick_i is a one-cycle enable at the clock-source rate, already
  gated by the run condition.
*/
`default_nettype none

module rcc_prescaler
  import rcc_pkg::*;
#(
  parameter int TICKS_PER_SEC = RTC_HZ
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Control
  input  wire logic             tick_i,
  input  wire logic [CAL_W-1:0] trim_i,
  input  wire logic             load_i,
  input  wire logic [5:0]       load_sec_i,
  // Status
  output logic      [5:0]       sec_o,
  output logic                  half_o,
  output logic                  sync_o
);

  localparam int CW   = $clog2(TICKS_PER_SEC + 513);
  localparam int HALF = TICKS_PER_SEC / 2;

  if (TICKS_PER_SEC < 1024) begin : g_chk
    $error("TICKS_PER_SEC must be at least 1024");
  end

  logic [CW-1:0] count;
  logic [5:0]    sec;
  logic [CW-1:0] last;

  // Last count of the given second; only the final second is trimmed
  function automatic logic [CW-1:0] sec_last(input logic [5:0] s,
                                             input logic [CAL_W-1:0] t);
    logic [CW+1:0] len;
    len = (CW+2)'(TICKS_PER_SEC);
    if (s == 6'(SEC_PER_MIN - 1)) begin
      len = len + {{(CW+2-CAL_W){t[CAL_W-1]}}, t};
    end
    sec_last = CW'(len - (CW+2)'(1));
  endfunction

  assign last = sec_last(sec, trim_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= '0;
      sec   <= '0;
    end else if (load_i) begin
      count <= '0;
      sec   <= (load_sec_i < 6'(SEC_PER_MIN)) ? load_sec_i : 6'h00;
    end else if (tick_i) begin
      if (count >= last) begin
        count <= '0;
        sec   <= (sec == 6'(SEC_PER_MIN - 1)) ? 6'h00 : sec + 6'h01;
      end else begin
        count <= count + CW'(1);
      end
    end
  end

  assign sec_o  = sec;
  assign half_o = (count >= CW'(HALF));
  assign sync_o = ((last - count) < CW'(SYNC_WIN));

endmodule

`default_nettype wire
